// [hw/hbp_pwm.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
// Function
// - Main control bit 0 enables all PWM outputs; clear disables them.
// - Bit 5, in H-bridge mode, swaps the active pair, holds the idle pair high and inverts outputs five and six.
// - Bit 4 forces outputs one and three high, two and four low.
// - Bit 3 copies compare registers to internal ones as timer steps 0 to 1.
// - Bit 2 picks outputs one/two active, else three/four; inverted swaps the pairs and holds the idle pair high.
// - Bit 1 selects H-bridge mode giving bits 2, 4 and 5 effect; else standard mode.
// - H-bridge, disabled, not forced: all four outputs 1; forced: 1,0,1,0.
// - H-bridge, enabled, uninverted: direction routes high/low side, idle pair 0.
// - H-bridge, enabled, inverted: direction routes high/low side, idle pair 1.
// - Main control resets to 0x12: high-side-off and bridge mode set.
// - After reset every PWM-capable pin is assigned its PWM function.
// - Any write to trip clear register clears pending trip unless a new trip edge comes in the same cycle; data ignored.
// - When enabled, convert start pulses a programmed delay after low side rises.
// - Delay longer than the low-side pulse keeps convert start low.
// - Convert start generated only while convert-start control bit 7 is set.
// - Delay code in bits 3:0 gives four times code plus one clocks.
// - One extra clock passes convert start to the ADC logic.
// - A trip input acts as safety cutoff and sources the trip interrupt.
module hbp_pwm
  import hbp_pkg::*;
#(
  parameter int CW = CMP_W
) (
  // Clock, reset and clock enable.
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  // Safety cutoff input.
  input  wire logic              trip_in,
  // Bridge outputs, pin function selects and ADC trigger.
  output logic [NUM_OUTS-1:0]    pwm_out,
  output logic [NUM_OUTS-1:0]    pwm_pin_func,
  output logic                   trip_pending,
  output logic                   convert_start
);

  typedef logic [CW-1:0] hbp_cmp_t;

  logic [MC_W-1:0]     main_ctrl_ff;
  logic [AT_W-1:0]     adc_trig_ff;
  hbp_cmp_t            cmp_a_ff [NUM_PAIRS];
  hbp_cmp_t            cmp_b_ff [NUM_PAIRS];
  hbp_cmp_t            cmp_c_ff [NUM_PAIRS];
  hbp_cmp_t            int_a_ff [NUM_PAIRS];
  hbp_cmp_t            int_b_ff [NUM_PAIRS];
  hbp_cmp_t            int_c_ff [NUM_PAIRS];
  hbp_cmp_t            cnt_ff;
  logic [7:0]          psc_ff;
  logic [DATA_W-1:0]   rdata_ff;
  logic [NUM_OUTS-1:0] pwm_out_ff;
  logic [NUM_OUTS-1:0] pin_func_ff;
  logic                trip_pend_ff;
  logic                trip_prev_ff;
  logic                ls_prev_ff;
  logic                cs_busy_ff;
  logic [CS_CNT_W-1:0] cs_cnt_ff;
  logic                cs_stage_ff;
  logic                cs_out_ff;

  logic [NUM_OUTS-1:0] nxt_pwm_out;
  logic [NUM_PAIRS-1:0] hs_raw;
  logic [NUM_PAIRS-1:0] ls_raw;
  logic                tick;
  logic                active_ls;
  logic [CS_CNT_W-1:0] cs_target;

  // High side runs from counter zero up to the first edge.
  function automatic logic hi_side(input hbp_cmp_t cnt, input hbp_cmp_t edge_a);
    hi_side = (cnt < edge_a);
  endfunction

  // Low side runs from its own edge up to, but not including, the period compare value.
  function automatic logic lo_side(input hbp_cmp_t cnt, input hbp_cmp_t edge_b,
                                   input hbp_cmp_t per);
    lo_side = (cnt >= edge_b) && (cnt < per);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  wire wr_main  = wr && hit(addr, ADR_MAIN_CTRL);
  wire wr_trig  = wr && hit(addr, ADR_ADC_TRIG);
  wire wr_clr   = wr && hit(addr, ADR_TRIP_CLR);
  wire trip_set = trip_in && !trip_prev_ff;

  // Prescaler: the counter steps once every 2^(code+1) clocks.
  // A new code acts at once, so the period in flight may come out long or short.
  wire [MC_PSC_W-1:0] psc_sel = main_ctrl_ff[MC_PSC_LO +: MC_PSC_W];
  wire [8:0]          psc_div = 9'h002 << psc_sel;
  assign tick = (psc_ff == 8'(psc_div - 9'h001));

  always_ff @(posedge mclk) begin
    if (rst) begin
      psc_ff <= 8'h00;
    end else if (ce) begin
      psc_ff <= tick ? 8'h00 : psc_ff + 8'h01;
    end
  end

  // Main control register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      main_ctrl_ff <= MC_RESET;
    end else if (ce && wr_main) begin
      main_ctrl_ff <= wdata[MC_W-1:0];
    end
  end

  // Convert-start control keeps reserved bits at zero whatever is written.
  always_ff @(posedge mclk) begin
    if (rst) begin
      adc_trig_ff <= AT_RESET;
    end else if (ce && wr_trig) begin
      adc_trig_ff <= wdata[AT_W-1:0] & AT_WMASK;
    end
  end

  // Compare registers, software side.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        cmp_a_ff[p] <= CMP_RESET;
        cmp_b_ff[p] <= CMP_RESET;
        cmp_c_ff[p] <= CMP_RESET;
      end
    end else if (ce && wr) begin
      if (hit(addr, ADR_P1_CMP_A)) begin
        cmp_a_ff[0] <= wdata[CW-1:0];
      end else if (hit(addr, ADR_P1_CMP_B)) begin
        cmp_b_ff[0] <= wdata[CW-1:0];
      end else if (hit(addr, ADR_P1_CMP_C)) begin
        cmp_c_ff[0] <= wdata[CW-1:0];
      end else if (hit(addr, ADR_P2_CMP_A)) begin
        cmp_a_ff[1] <= wdata[CW-1:0];
      end else if (hit(addr, ADR_P2_CMP_B)) begin
        cmp_b_ff[1] <= wdata[CW-1:0];
      end else if (hit(addr, ADR_P2_CMP_C)) begin
        cmp_c_ff[1] <= wdata[CW-1:0];
      end else if (hit(addr, ADR_P3_CMP_A)) begin
        cmp_a_ff[2] <= wdata[CW-1:0];
      end else if (hit(addr, ADR_P3_CMP_B)) begin
        cmp_b_ff[2] <= wdata[CW-1:0];
      end else if (hit(addr, ADR_P3_CMP_C)) begin
        cmp_c_ff[2] <= wdata[CW-1:0];
      end
    end
  end

  // Shared counter; pair one's period compare sets the wrap point.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (ce && tick) begin
      cnt_ff <= (cnt_ff >= int_c_ff[0]) ? '0 : cnt_ff + 1'b1;
    end
  end

  // With a zero period the counter never reaches 1, so the load also fires
  // from an idle counter; otherwise the timer could never be started.
  logic                boot_load;
  logic                step_load;
  assign boot_load = (int_c_ff[0] == '0) && main_ctrl_ff[MC_LOAD_COMPARE];
  // A running timer takes the new compares only as it steps from 0 to 1.
  assign step_load = (int_c_ff[0] != '0) && main_ctrl_ff[MC_LOAD_COMPARE];

  // Internal compares change only at the 0 to 1 step, or from the idle counter when the period is zero, so a period is never torn.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        int_a_ff[p] <= CMP_RESET;
        int_b_ff[p] <= CMP_RESET;
        int_c_ff[p] <= CMP_RESET;
      end
    end else if (ce && tick && cnt_ff == '0 && (step_load || boot_load)) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        int_a_ff[p] <= cmp_a_ff[p];
        int_b_ff[p] <= cmp_b_ff[p];
        int_c_ff[p] <= cmp_c_ff[p];
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PAIRS; p++) begin
      hs_raw[p] = hi_side(cnt_ff, int_a_ff[p]);
      ls_raw[p] = lo_side(cnt_ff, int_b_ff[p], int_c_ff[p]);
    end
  end

  // Output selection.
  always_comb begin
    logic en;
    logic inv;
    logic dir;
    logic high_side_off;
    en   = main_ctrl_ff[MC_EN];
    inv  = main_ctrl_ff[MC_INV];
    dir  = main_ctrl_ff[MC_DIR];
    high_side_off = main_ctrl_ff[MC_HIGH_SIDE_OFF];
    nxt_pwm_out = '0;
    if (main_ctrl_ff[MC_BRIDGE_MODE]) begin
      if (high_side_off) begin
        nxt_pwm_out[3:0] = 4'h5;
      end else if (!en) begin
        nxt_pwm_out[3:0] = 4'hf;
      end else if (!inv) begin
        // Idle pair held low, active pair carries high and low side.
        if (dir) begin
          nxt_pwm_out[3:0] = {2'b00, ls_raw[0], hs_raw[0]};
        end else begin
          nxt_pwm_out[3:0] = {ls_raw[0], hs_raw[0], 2'b00};
        end
      end else begin
        if (dir) begin
          nxt_pwm_out[3:0] = {ls_raw[0], hs_raw[0], 2'b11};
        end else begin
          nxt_pwm_out[3:0] = {2'b11, ls_raw[0], hs_raw[0]};
        end
      end
      nxt_pwm_out[5:4] = en ? {ls_raw[2], hs_raw[2]} : 2'b00;
      if (inv) begin
        nxt_pwm_out[5:4] = ~nxt_pwm_out[5:4];
      end
    end else begin
      nxt_pwm_out = en ? {ls_raw[2], hs_raw[2], ls_raw[1], hs_raw[1],
                          ls_raw[0], hs_raw[0]} : '0;
    end
    // The trip level overrides everything so the bridge is safe from the next clock edge.
    if (trip_in) begin
      nxt_pwm_out = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pwm_out_ff <= '0;
    end else if (ce) begin
      pwm_out_ff <= nxt_pwm_out;
    end
  end

  // Pin function: PWM capable pins come out of reset in PWM function.
  // No plain I/O mode is offered here, so the selects stay constant after reset.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_func_ff <= '1;
    end else if (ce) begin
      pin_func_ff <= '1;
    end
  end

  // Trip interrupt: a new trip edge wins over a clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      trip_prev_ff <= 1'b0;
      trip_pend_ff <= 1'b0;
    end else if (ce) begin
      trip_prev_ff <= trip_in;
      if (trip_set) begin
        trip_pend_ff <= 1'b1;
      end else if (wr_clr) begin
        trip_pend_ff <= 1'b0;
      end
    end
  end

  // Convert start follows the low side that is actually driven.
  // Outputs three and four carry the bridge when direction equals invert.
  always_comb begin
    if (main_ctrl_ff[MC_BRIDGE_MODE] && (main_ctrl_ff[MC_DIR] == main_ctrl_ff[MC_INV])) begin
      active_ls = nxt_pwm_out[3];
    end else begin
      active_ls = nxt_pwm_out[1];
    end
  end

  // A new rising edge restarts the count, so at most one convert start is pending.
  assign cs_target = CS_CNT_W'(CS_STEP) *
                     (CS_CNT_W'(adc_trig_ff[AT_DLY_LO +: AT_DLY_W]) + 7'h01);

  always_ff @(posedge mclk) begin
    if (rst) begin
      ls_prev_ff  <= 1'b0;
      cs_busy_ff  <= 1'b0;
      cs_cnt_ff   <= '0;
      cs_stage_ff <= 1'b0;
    end else if (ce) begin
      ls_prev_ff  <= active_ls;
      cs_stage_ff <= 1'b0;
      if (!adc_trig_ff[AT_CONVERT_START_ENABLE]) begin
        cs_busy_ff <= 1'b0;
      end else if (active_ls && !ls_prev_ff) begin
        cs_busy_ff <= 1'b1;
        cs_cnt_ff  <= 7'h01;
      end else if (cs_busy_ff) begin
        if (!active_ls) begin
          cs_busy_ff <= 1'b0;
        end else if (cs_cnt_ff == cs_target) begin
          cs_busy_ff  <= 1'b0;
          cs_stage_ff <= 1'b1;
        end else begin
          cs_cnt_ff <= cs_cnt_ff + 7'h01;
        end
      end
    end
  end

  // The extra stage models the hand-over into the ADC logic.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_out_ff <= 1'b0;
    end else if (ce) begin
      cs_out_ff <= cs_stage_ff && adc_trig_ff[AT_CONVERT_START_ENABLE];
    end
  end

  // Register read port: data stand the cycle after the strobe.
  // Status shows the live trip level beside the latched flag and the busy bit.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (ce) begin
      rdata_ff <= '0;
      if (rd) begin
        if (hit(addr, ADR_MAIN_CTRL)) begin
          rdata_ff <= DATA_W'(main_ctrl_ff);
        end else if (hit(addr, ADR_ADC_TRIG)) begin
          rdata_ff <= DATA_W'(adc_trig_ff);
        end else if (hit(addr, ADR_STATUS)) begin
          rdata_ff <= DATA_W'({cs_busy_ff, trip_in, trip_pend_ff});
        end else if (hit(addr, ADR_P1_CMP_A)) begin
          rdata_ff <= DATA_W'(cmp_a_ff[0]);
        end else if (hit(addr, ADR_P1_CMP_B)) begin
          rdata_ff <= DATA_W'(cmp_b_ff[0]);
        end else if (hit(addr, ADR_P1_CMP_C)) begin
          rdata_ff <= DATA_W'(cmp_c_ff[0]);
        end else if (hit(addr, ADR_P2_CMP_A)) begin
          rdata_ff <= DATA_W'(cmp_a_ff[1]);
        end else if (hit(addr, ADR_P2_CMP_B)) begin
          rdata_ff <= DATA_W'(cmp_b_ff[1]);
        end else if (hit(addr, ADR_P2_CMP_C)) begin
          rdata_ff <= DATA_W'(cmp_c_ff[1]);
        end else if (hit(addr, ADR_P3_CMP_A)) begin
          rdata_ff <= DATA_W'(cmp_a_ff[2]);
        end else if (hit(addr, ADR_P3_CMP_B)) begin
          rdata_ff <= DATA_W'(cmp_b_ff[2]);
        end else if (hit(addr, ADR_P3_CMP_C)) begin
          rdata_ff <= DATA_W'(cmp_c_ff[2]);
        end
      end
    end
  end

  assign rdata         = rdata_ff;
  assign pwm_out       = pwm_out_ff;
  assign pwm_pin_func  = pin_func_ff;
  assign trip_pending  = trip_pend_ff;
  assign convert_start = cs_out_ff;

endmodule

// [hw/hbp_pkg.sv]
package hbp_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CMP_W  = 16;
  localparam int NUM_PAIRS = 3;
  localparam int NUM_OUTS  = 6;

  // Register byte addresses.
  localparam logic [31:0] ADR_MAIN_CTRL = 32'hffff0f80;
  localparam logic [31:0] ADR_P1_CMP_A  = 32'hffff0f84;
  localparam logic [31:0] ADR_P1_CMP_B  = 32'hffff0f88;
  localparam logic [31:0] ADR_P1_CMP_C  = 32'hffff0f8c;
  localparam logic [31:0] ADR_ADC_TRIG  = 32'hffff0f90;
  localparam logic [31:0] ADR_P2_CMP_A  = 32'hffff0f94;
  localparam logic [31:0] ADR_P2_CMP_B  = 32'hffff0f98;
  localparam logic [31:0] ADR_P2_CMP_C  = 32'hffff0f9c;
  localparam logic [31:0] ADR_TRIP_CLR  = 32'hffff0fa0;
  localparam logic [31:0] ADR_P3_CMP_A  = 32'hffff0fa4;
  localparam logic [31:0] ADR_P3_CMP_B  = 32'hffff0fa8;
  localparam logic [31:0] ADR_P3_CMP_C  = 32'hffff0fac;
  localparam logic [31:0] ADR_STATUS    = 32'hffff0fb0;

  // Main control fields.
  localparam int MC_EN      = 0;
  localparam int MC_BRIDGE_MODE   = 1;
  localparam int MC_DIR     = 2;
  localparam int MC_LOAD_COMPARE   = 3;
  localparam int MC_HIGH_SIDE_OFF    = 4;
  localparam int MC_INV     = 5;
  localparam int MC_PSC_LO  = 6;
  localparam int MC_PSC_W   = 3;
  localparam int MC_W       = 9;
  localparam logic [8:0] MC_RESET = 9'h012;

  // Convert-start control fields.
  localparam int AT_DLY_LO = 0;
  localparam int AT_DLY_W  = 4;
  localparam int AT_CONVERT_START_ENABLE   = 7;
  localparam int AT_W      = 8;
  localparam logic [7:0] AT_RESET = 8'h00;
  localparam logic [7:0] AT_WMASK = 8'h8f;

  // Status fields.
  localparam int ST_TRIP_PEND = 0;
  localparam int ST_TRIP_LVL  = 1;
  localparam int ST_CS_BUSY   = 2;

  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam int CS_STEP = 4;
  localparam int CS_CNT_W = 7;

endpackage

// [dv/hbp_far_model.sv]
`timescale 1ns/10ps
module hbp_far_model (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst,
  // Power stage fault request and the trip line it drives.
  input  wire logic       fault,
  output logic            trip_in,
  // Convert start and the conversions the ADC logic began.
  input  wire logic       convert_start,
  output logic [7:0]      conv_cnt
);
  logic go_ff;

  // The stage comparator is clocked, so a fault reaches the trip line one edge later.
  always_ff @(posedge mclk) begin
    trip_in <= fault;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      go_ff <= 1'b0;
      conv_cnt <= 8'h00;
    end else begin
      go_ff <= convert_start;
      if (go_ff) begin
        conv_cnt <= conv_cnt + 8'h01;
      end
    end
  end
endmodule

// [dv/hbp_pwm_asserts.sv]
`timescale 1ns/10ps
module hbp_pwm_chk
  import hbp_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic                ce,
  // Register port.
  input wire logic [ADDR_W-1:0]   addr,
  input wire logic [DATA_W-1:0]   wdata,
  input wire logic                wr,
  input wire logic                rd,
  input wire logic [DATA_W-1:0]   rdata,
  // Trip and bridge side.
  input wire logic                trip_in,
  input wire logic [NUM_OUTS-1:0] pwm_out,
  input wire logic [NUM_OUTS-1:0] pwm_pin_func,
  input wire logic                trip_pending,
  input wire logic                convert_start
);
  logic [MC_W-1:0] mc_ff;
  logic            cs_en_ff;
  logic            base;
  logic            act;

  // Shadow copies of the control bits, kept from the bus so that no body signal is needed.
  always_ff @(posedge mclk) begin
    if (rst) begin
      mc_ff <= MC_RESET;
      cs_en_ff <= 1'b0;
    end else if (wr && ce && addr == ADR_MAIN_CTRL) begin
      mc_ff <= wdata[MC_W-1:0];
    end else if (wr && ce && addr == ADR_ADC_TRIG) begin
      cs_en_ff <= wdata[AT_CONVERT_START_ENABLE];
    end
  end

  assign base = ce && !trip_in && mc_ff[MC_BRIDGE_MODE] && !mc_ff[MC_HIGH_SIDE_OFF];
  assign act = base && mc_ff[MC_EN];

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  chk_pin_func: assert property (pwm_pin_func == 6'h3f)
    else $error("pin left out of pwm function");
  chk_trip_cut: assert property (ce && trip_in |=> pwm_out == '0)
    else $error("outputs live during trip");
  chk_trip_set: assert property (ce && $rose(trip_in) |=> trip_pending)
    else $error("trip not latched");
  chk_trip_clear: assert property (ce && wr && addr == ADR_TRIP_CLR && !$rose(trip_in) |=> !trip_pending)
    else $error("trip not cleared");
  chk_high_side_off_force: assert property (ce && !trip_in && mc_ff[MC_BRIDGE_MODE] && mc_ff[MC_HIGH_SIDE_OFF] |=> pwm_out[3:0] == 4'h5)
    else $error("high side off pattern wrong");
  chk_idle_high: assert property (base && !mc_ff[MC_EN] |=> pwm_out[3:0] == 4'hf)
    else $error("disabled bridge not all high");
  chk_pair_low: assert property (act && !mc_ff[MC_INV] |=>
    ($past(mc_ff[MC_DIR]) ? pwm_out[3:2] : pwm_out[1:0]) == 2'b00)
    else $error("idle pair not low");
  chk_pair_high: assert property (act && mc_ff[MC_INV] |=>
    ($past(mc_ff[MC_DIR]) ? pwm_out[1:0] : pwm_out[3:2]) == 2'b11)
    else $error("inverted idle pair not high");
  chk_cs_pulse: assert property (ce && convert_start |=> !convert_start)
    else $error("convert start longer than one cycle");
  chk_cs_off: assert property ((!cs_en_ff)[*2] |=> !convert_start)
    else $error("convert start while disabled");
  chk_rd_idle: assert property (ce && !rd |=> rdata == '0)
    else $error("read data outside read slot");
  chk_rd_main: assert property (ce && rd && addr == ADR_MAIN_CTRL |=> rdata == DATA_W'(mc_ff))
    else $error("main control read wrong");

  cov_cs: cover property (convert_start);
  cov_trip: cover property ($rose(trip_pending));
  cov_inv: cover property (act && mc_ff[MC_INV]);
endmodule

bind hbp_pwm hbp_pwm_chk hbp_pwm_chk_inst (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .trip_in(trip_in), .pwm_out(pwm_out), .pwm_pin_func(pwm_pin_func),
  .trip_pending(trip_pending), .convert_start(convert_start));

// [dv/hbp_pwm_test.sv]
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); \
    end \
  end
module hbp_pwm_test
  import hbp_pkg::*;
;
  logic                mclk;
  logic                rst;
  logic                ce;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic                wr;
  logic                rd;
  logic                fault;
  logic [DATA_W-1:0]   rdata;
  logic                trip_in;
  logic [NUM_OUTS-1:0] pwm_out;
  logic [NUM_OUTS-1:0] pwm_pin_func;
  logic                trip_pending;
  logic                convert_start;
  logic [7:0]          conv_cnt;
  int                  n_fail;
  int                  comparisons;
  int                  run_n;
  logic [31:0] cmp_adr [9] = '{ADR_P1_CMP_A, ADR_P1_CMP_B, ADR_P1_CMP_C, ADR_P2_CMP_A, ADR_P2_CMP_B,
                               ADR_P2_CMP_C, ADR_P3_CMP_A, ADR_P3_CMP_B, ADR_P3_CMP_C};
  // Control value, mask and expected level of outputs one to four.
  logic [15:0] out_tab [7] = '{16'h12f5, 16'h02ff, 16'h3ff5, 16'h03f0, 16'h07f0, 16'h23cc, 16'h2733};

  hbp_pwm hbp_pwm_inst (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trip_in(trip_in), .pwm_out(pwm_out), .pwm_pin_func(pwm_pin_func),
    .trip_pending(trip_pending), .convert_start(convert_start));
  hbp_far_model hbp_far_model_inst (.mclk(mclk), .rst(rst), .fault(fault), .trip_in(trip_in),
    .convert_start(convert_start), .conv_cnt(conv_cnt));

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    `CHK(rdata, e)
  endtask

  // The low side is made to rise by leaving high-side-off, since the counter stays idle here.
  task automatic cs_run(input logic [7:0] trig, input int cut, input int exp);
    int n;
    n = 0;
    wr_reg(ADR_MAIN_CTRL, 32'h16);
    wr_reg(ADR_ADC_TRIG, {24'h0, trig});
    wr_reg(ADR_MAIN_CTRL, 32'h06);
    while (pwm_out[1] !== 1'b1 && n < 9) begin
      @(negedge mclk);
      n++;
    end
    n = 0;
    while (convert_start !== 1'b1 && n < 80) begin
      @(negedge mclk);
      n++;
      if (n == cut) begin
        wr_reg(ADR_MAIN_CTRL, 32'h16);
      end
    end
    `CHK(n, exp)
  endtask

  // Counts the high clocks of one output over 48 clocks, four whole periods of the run test.
  task automatic count_high(input int b, output int n);
    n = 0;
    repeat (48) begin
      @(negedge mclk);
      n += int'(pwm_out[b] === 1'b1);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    fault = 1'b0;
    n_fail = 0;
    comparisons = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK(pwm_out[3:0], 4'h5)
    `CHK(pwm_pin_func, 6'h3f)
    rd_chk(ADR_MAIN_CTRL, 32'h12);
    rd_chk(ADR_ADC_TRIG, 32'h0);
    rd_chk(32'hffff0fb4, 32'h0);
    for (int k = 0; k < 9; k++) begin
      rd_chk(cmp_adr[k], 32'h0);
      wr_reg(cmp_adr[k], {16'h5a5a, 16'ha000 + 16'(k)});
      rd_chk(cmp_adr[k], {16'h0, 16'ha000 + 16'(k)});
      wr_reg(cmp_adr[k], 32'h0);
    end
    wr_reg(ADR_ADC_TRIG, 32'h8f);
    rd_chk(ADR_ADC_TRIG, 32'h8f);
    wr_reg(ADR_ADC_TRIG, 32'h0);
    wr_reg(ADR_MAIN_CTRL, 32'h1c2);
    ce <= 1'b0;
    wr_reg(ADR_MAIN_CTRL, 32'h3f);
    ce <= 1'b1;
    rd_chk(ADR_MAIN_CTRL, 32'h1c2);
    foreach (out_tab[k]) begin
      wr_reg(ADR_MAIN_CTRL, {24'h0, out_tab[k][15:8]});
      @(posedge mclk);
      @(negedge mclk);
      `CHK(pwm_out[3:0] & out_tab[k][7:4], out_tab[k][3:0])
    end
    wr_reg(ADR_MAIN_CTRL, 32'h02);
    fault <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK({trip_pending, pwm_out}, 7'h40)
    wr_reg(ADR_TRIP_CLR, 32'h0);
    rd_chk(ADR_STATUS, 32'h2);
    wr_reg(32'hffff0fb4, 32'hff);
    fault <= 1'b0;
    rd_chk(ADR_MAIN_CTRL, 32'h02);
    cs_run(8'h80, 0, 5);
    cs_run(8'h85, 0, 25);
    cs_run(8'h8f, 0, 65);
    cs_run(8'h0f, 0, 80);
    cs_run(8'h8f, 10, 80);
    `CHK(conv_cnt, 8'h03)
    wr_reg(ADR_P1_CMP_A, 32'h2);
    wr_reg(ADR_P1_CMP_B, 32'h3);
    wr_reg(ADR_P1_CMP_C, 32'h5);
    wr_reg(ADR_MAIN_CTRL, 32'h09);
    repeat (20) @(posedge mclk);
    count_high(0, run_n);
    `CHK(run_n, 16)
    count_high(1, run_n);
    `CHK(run_n, 16)
    wr_reg(ADR_MAIN_CTRL, 32'h01);
    wr_reg(ADR_P1_CMP_A, 32'h4);
    repeat (20) @(posedge mclk);
    count_high(0, run_n);
    `CHK(run_n, 16)
    wr_reg(ADR_MAIN_CTRL, 32'h09);
    repeat (20) @(posedge mclk);
    count_high(0, run_n);
    `CHK(run_n, 32)
    `CHK(pwm_out[5:2], 4'h0)
    `CHK(conv_cnt, 8'h03)
    give_verdict();
  end
endmodule
